// ===== crms_core_regs.sv
/*
  Core register set with mode and stack pointer selection.
  Assumes the execution and exception logic of the same core drives the requests below
  and returns vector fetch data in the cycle after each fetch request.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// (RL1) Reset leaves the core in application (thread) mode.
// (RL2) Handler mode holds until exception logic reports all exceptions done.
// (RL3) Push decrements the active pointer first, then writes at the new address.
// (RL4) Two stack pointers; control bit 1 picks process pointer in thread mode.
// (RL5) Handler mode always uses the main stack pointer.
// (RL6) Reset fetches word at address 0 into the main stack pointer.
// (RL7) Reset loads program counter from the vector word at address 4.
// (RL8) State bit 24 loads from bit 0 of the reset vector.
// (RL9) Thirteen data registers, then stack pointer, link, program counter.
// (RL10) Link, data registers and process pointer are unknown after reset.
// (RL11) Flags N Z C V at bits 31 to 28; lower bits reserved.
// (RL12) Bits 5:0 carry the active exception number.
// (RL13) Exception number resets to zero; software writes never change it.
// (RL14) State field reads zero to software and ignores software writes.
// (RL15) Status fields reachable singly, in pairs or all three by selector.
// (RL16) State bit changes only by exchange branches, pop, return or vector; the code leaves it unchanged on pops and pc_we writes.
// (RL17) Executing with state bit zero raises a hard fault instead.
// (RL18) Interrupted load or store multiple restarts from its first transfer.
// (RL19) Priority mask bit 0 blocks configurable-priority exceptions when set.
// (RL20) Mask writable by move instructions and change-processor-state.
// (RL21) In handler mode the stack-select bit reads zero and ignores writes.
// (RL22) Reserved bits read as zero and ignore writes.
module crms_core_regs
  import crms_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  output logic boot_fetch_req,
  output logic [31:0] boot_fetch_addr,
  input wire logic [31:0] boot_fetch_data,
  input wire logic gpr_we,
  input wire logic [3:0] gpr_waddr,
  input wire logic [31:0] gpr_wdata,
  input wire logic [3:0] gpr_raddr,
  output logic [31:0] gpr_rdata,
  input wire logic flags_we,
  input wire logic [3:0] flags_in,
  input wire logic sreg_wr,
  input wire logic sreg_rd,
  input wire crms_pkg::crms_sreg_t sreg_sel,
  input wire logic [31:0] sreg_wdata,
  output logic [31:0] sreg_rdata,
  input wire logic cps_we,
  input wire logic cps_mask,
  input wire logic exc_entry,
  input wire logic [5:0] exc_number,
  input wire logic [31:0] exc_vector,
  input wire logic exc_return,
  input wire logic [31:0] exc_stacked_psw,
  input wire logic all_exc_done,
  input wire logic exchange_branch,
  input wire logic [31:0] exchange_target,
  input wire logic pc_we,
  input wire logic [31:0] pc_wdata,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic sp_we,
  input wire logic [31:0] sp_wdata,
  input wire logic exec_req,
  input wire logic multi_active,
  input wire logic [31:0] multi_start_pc,
  input wire logic irq_taken,
  output logic [31:0] program_counter,
  output logic [31:0] active_sp,
  output logic [31:0] push_addr,
  output logic push_strobe,
  output logic handler_mode,
  output logic priority_mask,
  output logic hard_fault_req,
  output logic multi_restart,
  output logic [31:0] program_status_word,
  output logic running
);
  crms_boot_t boot_q;
  crms_boot_t boot_d;
  crms_mode_t mode_q;
  logic [31:0] main_stack_pointer_q;
  logic [31:0] process_stack_pointer_q;
  logic [31:0] pc_q;
  logic [3:0] flags_q;
  logic [5:0] exc_q;
  logic state_q;
  logic mask_q;
  logic stack_sel_q;
  logic [31:0] push_addr_q;
  logic push_strobe_q;
  logic fault_q;
  logic restart_q;
  logic [31:0] sreg_rdata_q;

  // Decrement by one word, shared by the push path and its address output.
  function automatic logic [31:0] sp_dec(input logic [31:0] sp);
    sp_dec = sp - WORD_BYTES;
  endfunction : sp_dec

  function automatic logic [31:0] sp_inc(input logic [31:0] sp);
    sp_inc = sp + WORD_BYTES;
  endfunction : sp_inc

  wire in_handler = (mode_q == MODE_HANDLER);
  wire boot_done = (boot_q == BOOT_RUN);
  // (RL5) handler uses main
  wire use_process = stack_sel_q && !in_handler;
  wire [31:0] cur_sp = use_process ? process_stack_pointer_q : main_stack_pointer_q;
  wire [31:0] cur_sp_next = sp_push ? sp_dec(cur_sp) : sp_pop ? sp_inc(cur_sp) : sp_wdata;
  wire sp_change = boot_done && (sp_push || sp_pop || sp_we);
  // (RL15) field selection decode
  wire sel_flags = (sreg_sel == SR_FLAGS) || (sreg_sel == SR_FLAGS_NUMBER) ||
    (sreg_sel == SR_FLAGS_STATE) || (sreg_sel == SR_ALL);
  wire sel_number = (sreg_sel == SR_NUMBER) || (sreg_sel == SR_FLAGS_NUMBER) ||
    (sreg_sel == SR_NUMBER_STATE) || (sreg_sel == SR_ALL);
  wire sel_control = (sreg_sel == SR_CONTROL);
  wire sw_flag_wr = boot_done && sreg_wr && sel_flags;
  // (RL21) handler ignores stack-select writes
  wire sw_ctrl_wr = boot_done && sreg_wr && sel_control && !in_handler;
  wire [31:0] flags_word = {flags_q, 28'h000_0000};
  wire [31:0] number_word = {26'h000_0000, exc_q};
  // (RL14) state field reads zero
  wire [31:0] sreg_read_word =
    sel_control ? {30'h0000_0000, (stack_sel_q && !in_handler), mask_q} :
    ((sel_flags ? flags_word : 32'h0000_0000) | (sel_number ? number_word : 32'h0000_0000));
  wire [31:0] psw_word = {flags_q, 3'h0, state_q, 18'h0_0000, exc_q};
  // (RL17) execution with state zero faults
  wire fault_now = boot_done && exec_req && !state_q;
  // (RL18) abandoned multiple transfer
  wire restart_now = boot_done && irq_taken && multi_active;

  // (RL6) (RL7) boot fetch sequence
  // Each vector word arrives one cycle after its address, so the reset vector
  // needs a load cycle of its own after the stack word has been taken.
  always_comb
  begin
    boot_d = boot_q;
    unique case (boot_q)
      BOOT_FETCH_SP: boot_d = BOOT_FETCH_PC;
      BOOT_FETCH_PC: boot_d = BOOT_LOAD_PC;
      BOOT_LOAD_PC: boot_d = BOOT_RUN;
      BOOT_RUN: boot_d = BOOT_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_q <= BOOT_FETCH_SP;
    end
    else
    begin
      boot_q <= boot_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_fetch_req <= 1'b1;
      boot_fetch_addr <= MAIN_SP_VECTOR_ADDR;
    end
    else
    begin
      boot_fetch_req <= (boot_d == BOOT_FETCH_PC);
      boot_fetch_addr <= RESET_VECTOR_ADDR;
    end
  end

  // (RL1) (RL2) mode control
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_THREAD;
    end
    else if (boot_done && exc_entry)
    begin
      mode_q <= MODE_HANDLER;
    end
    else if (boot_done && exc_return && all_exc_done)
    begin
      mode_q <= MODE_THREAD;
    end
  end

  // (RL12) (RL13) exception number from hardware only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_q <= EXC_NONE;
    end
    else if (boot_done && exc_entry)
    begin
      exc_q <= exc_number;
    end
    else if (boot_done && exc_return)
    begin
      exc_q <= all_exc_done ? EXC_NONE : exc_stacked_psw[EXC_MSB:0];
    end
  end

  // (RL6) main pointer from word 0, (RL3) full-descending updates
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_stack_pointer_q <= MAIN_SP_VECTOR_ADDR;
    end
    else if (boot_q == BOOT_FETCH_PC)
    begin
      main_stack_pointer_q <= boot_fetch_data;
    end
    else if (sp_change && !use_process)
    begin
      main_stack_pointer_q <= cur_sp_next;
    end
  end

  // (RL10) process pointer has no reset value
  always_ff @(posedge core_clk)
  begin
    if (sp_change && use_process)
    begin
      process_stack_pointer_q <= cur_sp_next;
    end
  end

  // (RL3) push strobe with pre-decremented address
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_addr_q <= 32'h0000_0000;
      push_strobe_q <= 1'b0;
    end
    else
    begin
      push_addr_q <= sp_dec(cur_sp);
      push_strobe_q <= boot_done && sp_push;
    end
  end

  // (RL7) program counter from reset vector, (RL18) restart point
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q <= 32'h0000_0000;
    end
    else if (boot_q == BOOT_RUN && restart_now)
    begin
      pc_q <= multi_start_pc;
    end
    else if (boot_q == BOOT_RUN && exc_entry)
    begin
      pc_q <= exc_vector;
    end
    else if (boot_q == BOOT_RUN && exchange_branch)
    begin
      pc_q <= exchange_target;
    end
    else if (boot_q == BOOT_RUN && pc_we)
    begin
      pc_q <= pc_wdata;
    end
    else if (boot_q == BOOT_LOAD_PC)
    begin
      pc_q <= boot_fetch_data;
    end
  end

  // (RL8) (RL16) state bit sources
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= 1'b0;
    end
    else if (boot_q == BOOT_LOAD_PC)
    begin
      state_q <= boot_fetch_data[0];
    end
    else if (boot_done && exc_entry)
    begin
      state_q <= exc_vector[0];
    end
    else if (boot_done && exc_return)
    begin
      state_q <= exc_stacked_psw[STATE_BIT];
    end
    else if (boot_done && exchange_branch)
    begin
      state_q <= exchange_target[0];
    end
  end

  // (RL11) flags from results or software
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_q <= {FLAGS_RESET, FLAGS_RESET};
    end
    else if (boot_done && exc_return)
    begin
      flags_q <= exc_stacked_psw[FLAG_N_BIT:FLAG_V_BIT];
    end
    else if (boot_done && flags_we)
    begin
      flags_q <= flags_in;
    end
    else if (sw_flag_wr)
    begin
      flags_q <= sreg_wdata[FLAG_N_BIT:FLAG_V_BIT];
    end
  end

  // (RL19) (RL20) priority mask writes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= PRIO_MASK_RESET;
    end
    else if (boot_done && cps_we)
    begin
      mask_q <= cps_mask;
    end
    else if (boot_done && sreg_wr && sel_control)
    begin
      mask_q <= sreg_wdata[PRIO_MASK_BIT];
    end
  end

  // (RL4) stack select bit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_sel_q <= STACK_SEL_RESET;
    end
    else if (sw_ctrl_wr)
    begin
      stack_sel_q <= sreg_wdata[STACK_SEL_BIT];
    end
  end

  // (RL22) read data with reserved bits zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sreg_rdata_q <= 32'h0000_0000;
      fault_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      sreg_rdata_q <= sreg_rd ? sreg_read_word : 32'h0000_0000;
      fault_q <= fault_now;
      restart_q <= restart_now;
    end
  end

  // (RL9) (RL10) data registers and link register
  crms_gpr_mem u_gpr
  (
    .core_clk(core_clk),
    .we(gpr_we && boot_done && gpr_waddr != REG_SP && gpr_waddr != REG_PC),
    .waddr(gpr_waddr),
    .wdata(gpr_wdata),
    .raddr(gpr_raddr),
    .rdata(gpr_rdata)
  );

  assign program_counter = pc_q;
  assign active_sp = cur_sp;
  assign push_addr = push_addr_q;
  assign push_strobe = push_strobe_q;
  assign handler_mode = in_handler;
  assign priority_mask = mask_q;
  assign hard_fault_req = fault_q;
  assign multi_restart = restart_q;
  assign program_status_word = psw_word;
  assign running = boot_done;
  assign sreg_rdata = sreg_rdata_q;

  // Checks.
  a_reset_thread: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL1)
    $rose(running) |-> !handler_mode)
    else $error("not thread mode after boot");
  a_handler_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL2)
    (handler_mode && !(exc_return && all_exc_done)) |=> handler_mode)
    else $error("left handler mode early");
  a_push_descend: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL3)
    (running && sp_push) |=> active_sp == push_addr)
    else $error("push not predecrement");
  a_handler_main: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL5)
    handler_mode |-> active_sp == main_stack_pointer_q)
    else $error("handler not on main");
  a_number_fixed: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL13)
    (!exc_entry && !exc_return) |=> $stable(exc_q))
    else $error("number changed");
  a_state_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL14)
    (sreg_rd && sel_flags) |=> sreg_rdata[STATE_BIT] == 1'b0)
    else $error("state visible");
  a_fault_state: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL17)
    (running && exec_req && !program_status_word[STATE_BIT]) |=> hard_fault_req)
    else $error("no fault on state zero");
  a_ctrl_handler: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL21)
    (handler_mode && sreg_rd && sel_control) |=> sreg_rdata[STACK_SEL_BIT] == 1'b0)
    else $error("select visible in handler");
  a_restart_pc: assert property (@(posedge core_clk) disable iff (!rst_n) // (RL18)
    restart_now |=> program_counter == $past(multi_start_pc))
    else $error("no restart");
endmodule : crms_core_regs
`default_nettype wire

// ===== crms_pkg.sv
/*
  Package of the core register and mode/stack block: layouts, codes and reset values.
  Assumes it is compiled before the design modules that import it.
*/
`default_nettype none
package crms_pkg;
  localparam int unsigned XLEN = 32;
  localparam logic [XLEN-1:0] MAIN_SP_VECTOR_ADDR = 32'h0000_0000;
  localparam logic [XLEN-1:0] RESET_VECTOR_ADDR = 32'h0000_0004;
  localparam logic [XLEN-1:0] WORD_BYTES = 32'h0000_0004;
  localparam int unsigned FLAG_N_BIT = 31;
  localparam int unsigned FLAG_Z_BIT = 30;
  localparam int unsigned FLAG_C_BIT = 29;
  localparam int unsigned FLAG_V_BIT = 28;
  localparam int unsigned STATE_BIT = 24;
  localparam int unsigned EXC_MSB = 5;
  localparam int unsigned STACK_SEL_BIT = 1;
  localparam int unsigned PRIO_MASK_BIT = 0;
  localparam logic [5:0] EXC_NONE = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
  localparam logic [5:0] EXC_SVC = 6'h0b;
  localparam logic [5:0] EXC_PENDSERV = 6'h0e;
  localparam logic [5:0] EXC_TICK = 6'h0f;
  localparam logic [5:0] EXC_IRQ_FIRST = 6'h10;
  localparam logic [5:0] EXC_IRQ_LAST = 6'h2f;
  localparam logic [3:0] REG_SP = 4'hd;
  localparam logic [3:0] REG_LINK = 4'he;
  localparam logic [3:0] REG_PC = 4'hf;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic PRIO_MASK_RESET = 1'b0;
  localparam logic STACK_SEL_RESET = 1'b0;

  // Special-register selector of the move instructions.
  typedef enum logic [2:0]
  {
    SR_FLAGS,
    SR_NUMBER,
    SR_STATE,
    SR_FLAGS_NUMBER,
    SR_FLAGS_STATE,
    SR_NUMBER_STATE,
    SR_ALL,
    SR_CONTROL
  } crms_sreg_t;

  typedef enum logic
  {
    MODE_THREAD,
    MODE_HANDLER
  } crms_mode_t;

  typedef enum logic [1:0]
  {
    BOOT_FETCH_SP,
    BOOT_FETCH_PC,
    BOOT_LOAD_PC,
    BOOT_RUN
  } crms_boot_t;
endpackage : crms_pkg
`default_nettype wire

// ===== crms_gpr_mem.sv
/*
  Register bank of fifteen words: thirteen general-purpose words, the stack pointer slot (13) and link register.
  Assumes one write and one read per cycle on core_clk; read data registered.
*/
`timescale 1ns/10ps
`default_nettype none
module crms_gpr_mem
(
  core_clk,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input wire logic core_clk;
  input wire logic we;
  input wire logic [3:0] waddr;
  input wire logic [31:0] wdata;
  input wire logic [3:0] raddr;
  output var logic [31:0] rdata;

  logic [31:0] mem_q [0:14];

  // Contents are unknown after reset, so the array has no reset.
  always_ff @(posedge core_clk)
  begin
    if (we && waddr <= 4'he)
    begin
      mem_q[waddr] <= wdata;
    end
    rdata <= (raddr <= 4'he) ? mem_q[raddr] : 32'h0000_0000;
  end
endmodule : crms_gpr_mem
`default_nettype wire

// ===== crms_vec_mem.sv
/*
  Vector word store that answers the boot fetches of the core register block.
  Assumes a fetch is answered with the word of the previous cycle's address.
*/
`timescale 1ns/10ps
`default_nettype none
module crms_vec_mem
#(
  parameter logic [31:0] SP_WORD = 32'h2000_0400,
  parameter logic [31:0] PC_WORD = 32'h0000_0201
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic boot_fetch_req,
  input wire logic [31:0] boot_fetch_addr,
  output var logic [31:0] boot_fetch_data
);
  // Outside a fetch the data lines invert every cycle, so the last word returns every other cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      boot_fetch_data <= 32'h0000_0000;
    else if (boot_fetch_req)
      boot_fetch_data <= (boot_fetch_addr == 32'h0000_0004) ? PC_WORD : SP_WORD;
    else
      boot_fetch_data <= ~boot_fetch_data;
  end
endmodule : crms_vec_mem
`default_nettype wire

// ===== crms_core_regs_tb.sv
/*
  Self-checking bench of the core register block.
  Assumes the vector store model answers boot fetches; inputs change on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module crms_core_regs_tb;
  import crms_pkg::*;
  localparam logic [31:0] SPW = 32'h2000_0400;
  localparam logic [31:0] PCW = 32'h0000_0201;
  typedef struct packed {crms_sreg_t sw; logic [31:0] wd; crms_sreg_t sr; logic [31:0] ex;} crms_row_t;
  logic core_clk, rst_n, boot_fetch_req, gpr_we, flags_we, sreg_wr, sreg_rd, cps_we, cps_mask;
  logic exc_entry, exc_return, all_exc_done, exchange_branch, pc_we, sp_push, sp_pop, sp_we;
  logic exec_req, multi_active, irq_taken, push_strobe, handler_mode, priority_mask;
  logic hard_fault_req, multi_restart, running;
  logic [3:0] gpr_waddr, gpr_raddr, flags_in;
  logic [5:0] exc_number;
  logic [31:0] boot_fetch_addr, boot_fetch_data, gpr_wdata, gpr_rdata, sreg_wdata, sreg_rdata;
  logic [31:0] exc_vector, exc_stacked_psw, exchange_target, pc_wdata, sp_wdata, multi_start_pc;
  logic [31:0] program_counter, active_sp, push_addr, program_status_word, rd;
  crms_sreg_t sreg_sel;
  int n_mismatch = 0;
  int num_checks = 0;
  crms_row_t rows [8] = '{
    '{SR_FLAGS, 32'h5fff_ffff, SR_FLAGS, 32'h5000_0000},
    '{SR_FLAGS_NUMBER, 32'ha000_003f, SR_FLAGS_NUMBER, 32'ha000_0000},
    '{SR_FLAGS_STATE, 32'h3100_0000, SR_FLAGS_STATE, 32'h3000_0000},
    '{SR_NUMBER_STATE, 32'hffff_ffff, SR_ALL, 32'h3000_0000},
    '{SR_ALL, 32'hc1ff_ffff, SR_STATE, 32'h0000_0000},
    '{SR_NUMBER, 32'hffff_ffff, SR_NUMBER, 32'h0000_0000},
    '{SR_CONTROL, 32'hffff_ffff, SR_CONTROL, 32'h0000_0003},
    '{SR_CONTROL, 32'h0000_0002, SR_CONTROL, 32'h0000_0002}};

  crms_core_regs dut (.*);
  crms_vec_mem #(.SP_WORD(SPW), .PC_WORD(PCW)) vmem (.core_clk(core_clk), .rst_n(rst_n),
    .boot_fetch_req(boot_fetch_req), .boot_fetch_addr(boot_fetch_addr),
    .boot_fetch_data(boot_fetch_data));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    num_checks++;
    if (seen !== ex)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic wait_boot();
    for (int i = 0; i < 20 && running !== 1'b1; i++)
      @(negedge core_clk);
    if (running !== 1'b1)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : wait_boot

  task automatic swr(input crms_sreg_t s, input logic [31:0] w);
    @(negedge core_clk);
    sreg_sel = s;
    sreg_wdata = w;
    sreg_wr = 1'b1;
    @(negedge core_clk);
    sreg_wr = 1'b0;
  endtask : swr

  task automatic srd(input crms_sreg_t s);
    @(negedge core_clk);
    sreg_sel = s;
    sreg_rd = 1'b1;
    @(negedge core_clk);
    sreg_rd = 1'b0;
    rd = sreg_rdata;
  endtask : srd

  initial
  begin
    {rst_n, gpr_we, flags_we, sreg_wr, sreg_rd, cps_we, cps_mask, exc_entry, exc_return} = '0;
    {all_exc_done, exchange_branch, pc_we, sp_push, sp_pop, sp_we, exec_req} = '0;
    {multi_active, irq_taken, gpr_waddr, gpr_raddr, flags_in, exc_number} = '0;
    {gpr_wdata, sreg_wdata, exc_vector, exc_stacked_psw, exchange_target} = '0;
    {pc_wdata, sp_wdata, multi_start_pc} = '0;
    sreg_sel = SR_FLAGS;
    repeat (8) @(negedge core_clk);
    chk("reset mode", {31'h0, handler_mode}, 32'h0);
    chk("reset mask", {31'h0, priority_mask}, 32'h0);
    rst_n = 1'b1;
    wait_boot();
    chk("boot sp", active_sp, SPW);
    chk("boot req", {31'h0, boot_fetch_req}, 32'h0);
    chk("boot addr", boot_fetch_addr, RESET_VECTOR_ADDR);
    chk("boot pc", program_counter, PCW);
    chk("boot state", {31'h0, program_status_word[STATE_BIT]}, 32'h1);
    chk("boot number", {26'h0, program_status_word[5:0]}, 32'h0);
    $display("test done: reset");
    // Special-register writes followed by reads through every selector except SR_NUMBER_STATE.
    foreach (rows[i])
    begin
      swr(rows[i].sw, rows[i].wd);
      srd(rows[i].sr);
      chk(rows[i].sr.name(), rd, rows[i].ex);
    end
    $display("test done: status views");
    @(negedge core_clk);
    sp_wdata = 32'h2000_1000;
    sp_we = 1'b1;
    @(negedge core_clk);
    sp_we = 1'b0;
    sp_push = 1'b1;
    @(negedge core_clk);
    sp_push = 1'b0;
    chk("push strobe", {31'h0, push_strobe}, 32'h1);
    chk("push addr", push_addr, 32'h2000_0ffc);
    chk("process sp", active_sp, 32'h2000_0ffc);
    swr(SR_CONTROL, 32'h0);
    chk("main sp", active_sp, SPW);
    swr(SR_CONTROL, 32'h2);
    $display("test done: stacks");
    @(negedge core_clk);
    exc_number = EXC_TICK;
    exc_vector = 32'h0000_0301;
    exc_entry = 1'b1;
    @(negedge core_clk);
    exc_entry = 1'b0;
    chk("entry mode", {31'h0, handler_mode}, 32'h1);
    chk("entry number", {26'h0, program_status_word[5:0]}, {26'h0, EXC_TICK});
    chk("handler sp", active_sp, SPW);
    swr(SR_CONTROL, 32'h0);
    srd(SR_CONTROL);
    chk("handler ctrl", rd, 32'h0);
    @(negedge core_clk);
    exc_return = 1'b1;
    @(negedge core_clk);
    exc_return = 1'b0;
    chk("still handler", {31'h0, handler_mode}, 32'h1);
    @(negedge core_clk);
    all_exc_done = 1'b1;
    exc_return = 1'b1;
    @(negedge core_clk);
    exc_return = 1'b0;
    chk("return mode", {31'h0, handler_mode}, 32'h0);
    chk("return state", {31'h0, program_status_word[STATE_BIT]}, 32'h0);
    exec_req = 1'b1;
    @(negedge core_clk);
    exec_req = 1'b0;
    chk("fault", {31'h0, hard_fault_req}, 32'h1);
    exchange_target = 32'h0000_0401;
    exchange_branch = 1'b1;
    @(negedge core_clk);
    exchange_branch = 1'b0;
    chk("exchange state", {31'h0, program_status_word[STATE_BIT]}, 32'h1);
    exec_req = 1'b1;
    @(negedge core_clk);
    exec_req = 1'b0;
    chk("no fault", {31'h0, hard_fault_req}, 32'h0);
    $display("test done: exceptions");
    multi_active = 1'b1;
    multi_start_pc = 32'h0000_0500;
    irq_taken = 1'b1;
    @(negedge core_clk);
    irq_taken = 1'b0;
    multi_active = 1'b0;
    chk("restart", {31'h0, multi_restart}, 32'h1);
    chk("restart pc", program_counter, 32'h0000_0500);
    cps_mask = 1'b1;
    cps_we = 1'b1;
    flags_in = 4'h9;
    flags_we = 1'b1;
    @(negedge core_clk);
    {cps_we, flags_we} = '0;
    chk("cps mask", {31'h0, priority_mask}, 32'h1);
    chk("flags", {28'h0, program_status_word[31:28]}, 32'h9);
    gpr_waddr = 4'hc;
    gpr_wdata = 32'h1234_5678;
    gpr_we = 1'b1;
    @(negedge core_clk);
    gpr_we = 1'b0;
    gpr_raddr = 4'hc;
    @(negedge core_clk);
    chk("gpr 12", gpr_rdata, 32'h1234_5678);
    gpr_waddr = REG_LINK;
    gpr_wdata = 32'h0000_0a5a;
    gpr_we = 1'b1;
    @(negedge core_clk);
    gpr_we = 1'b0;
    gpr_raddr = REG_LINK;
    @(negedge core_clk);
    chk("link", gpr_rdata, 32'h0000_0a5a);
    $display("test done: misc");
    // A reset taken in handler mode must come back in thread mode with a fresh boot.
    exc_entry = 1'b1;
    @(negedge core_clk);
    exc_entry = 1'b0;
    chk("entry again", {31'h0, handler_mode}, 32'h1);
    rst_n = 1'b0;
    @(negedge core_clk);
    chk("mid reset mode", {31'h0, handler_mode}, 32'h0);
    rst_n = 1'b1;
    wait_boot();
    chk("reboot sp", active_sp, SPW);
    chk("reboot pc", program_counter, PCW);
    $display("test done: mid reset");
    end_of_test();
  end
endmodule : crms_core_regs_tb
`default_nettype wire
